//--- pfm_word_consts.svh
// Register map, field positions and reset values of the octal word assembler
`ifndef PFM_WORD_CONSTS_SVH
`define PFM_WORD_CONSTS_SVH
`define REG_CTRL 12'h000
`define REG_IRQ_STAT 12'h004
`define REG_IRQ_CLR 12'h008
`define REG_IRQ_EN 12'h00C
`define REG_MEAS 12'h010
`define REG_FULL 12'h014
`define REG_LIM_BASE 12'h040
`define REG_LIM_END 12'h088
`define REG_MARK_BASE 12'h400
`define REG_HOLD_BASE 12'h600
`define CTRL_EN_BIT 0
`define CTRL_RATIO_LSB 4
`define CTRL_AVG_LSB 8
`define CTRL_RST 32'h0000_0A00
`define CTRL_WMASK 32'h0000_3F71
`define MARK_CHAN_LSB 0
`define MARK_DIGIT_LSB 8
`define MARK_WORD_LSB 12
`define MARK_LAST_BIT 16
`define MARK_EN_BIT 31
`define MARK_WMASK 32'h8001_77FF
`define MEAS_DIGIT_LSB 16
`define MEAS_HIT_BIT 20
`define MEAS_SYNC_BIT 21
`define MEAS_OVF_BIT 22
`define LIM_RST 13'h0000
`define LIM_SYNC_IDX 16
`define IRQ_FULL_BIT 0
`define IRQ_SYNC_BIT 1
`define IRQ_RANGE_BIT 2
`define IRQ_OVF_BIT 3
`endif

//--- pfm_word_pkg.sv
// Types shared by the octal word assembler files
package pfm_word_pkg;
   // Counter clock ratio codes
   typedef enum logic [2:0] {
      RATIO_DIV16 = 3'h0, RATIO_DIV8 = 3'h1, RATIO_DIV4 = 3'h2,
      RATIO_DIV2 = 3'h3, RATIO_DIV1 = 3'h4
   } clk_ratio_t;
   // Period meter states, Gray along wait to run
   typedef enum logic [1:0] {MS_WAIT = 2'b00, MS_RUN = 2'b01} meas_state_t;
   // Period count and limit value
   typedef logic [12:0] period_t;
endpackage

//--- pfm_meas_if.sv
// Measurement result path from the period meter to the word logic
`timescale 1ns/1ns
interface pfm_meas_if;
   logic done;
   logic [2:0] digit;
   logic in_range;
   logic sync_hit;
   logic ovf;
   pfm_word_pkg::period_t count;
   modport meter (output done, digit, in_range, sync_hit, ovf, count);
   modport user (input done, digit, in_range, sync_hit, ovf, count);
endinterface

//--- pfm_mem_cell.sv
// One memory cell: stores one digit bit of one word
`timescale 1ns/1ns
module pfm_mem_cell (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic mark,
   input wire logic info,
   input wire logic xfer,
   input wire logic clr,
   output logic q_out
);
   logic q_r; // Stored bit
   // Clear dominates; marks never land in the clear cycle
   always_ff @(posedge mclk) begin
      if (sys_rst || clr) begin
         q_r <= 1'b0;
      end else if (mark) begin
         q_r <= info;
      end
   end
   // Bit reaches the hold register only during transfer
   assign q_out = q_r & xfer;
endmodule

//--- pfm_period_meter.sv
// Period meter: divided-clock counter over N periods, limit compare
`timescale 1ns/1ns
`include "pfm_word_consts.svh"
module pfm_period_meter (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic pfm_in,
   input wire logic [2:0] ratio,
   input wire logic [5:0] avg_periods,
   input wire logic [7:0][12:0] lim_hi,
   input wire logic [7:0][12:0] lim_lo,
   input wire logic [12:0] sync_hi,
   input wire logic [12:0] sync_lo,
   input wire logic sync_win,
   pfm_meas_if.meter m
);
   pfm_word_pkg::meas_state_t state_r;
   logic pfm_q_r; // Previous input level
   logic [3:0] div_r; // Prescaler
   logic [3:0] div_mask; // Prescaler terminal mask
   logic [12:0] cnt_r; // Period counter
   logic [5:0] per_r; // Periods seen in interval
   logic ovf_r; // Counter saturated
   logic rise, tick, last_per, hit_nxt, sync_nxt;
   logic [2:0] dig_nxt;
   logic done_r, hit_r, sync_r, movf_r;
   logic [2:0] dig_r;
   logic [12:0] count_r;
   assign rise = pfm_in & ~pfm_q_r;
   assign div_mask = 4'hF >> ratio;
   assign tick = (div_r & div_mask) == div_mask;
   assign last_per = (per_r + 6'h01) == avg_periods;
   // Edge detect and prescaler
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pfm_q_r <= 1'b0;
         div_r <= 4'h0;
      end else begin
         pfm_q_r <= pfm_in;
         div_r <= div_r + 4'h1;
      end
   end
   // Wait for the first edge, then measure back to back
   always_ff @(posedge mclk) begin
      if (sys_rst || !enable) begin
         state_r <= pfm_word_pkg::MS_WAIT;
      end else if (rise) begin
         state_r <= pfm_word_pkg::MS_RUN;
      end
   end
   // Counter restarts each interval and saturates
   always_ff @(posedge mclk) begin
      if (sys_rst || state_r == pfm_word_pkg::MS_WAIT || (rise && last_per)) begin
         cnt_r <= 13'h0000;
         ovf_r <= 1'b0;
      end else if (tick) begin
         if (&cnt_r) begin
            ovf_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 13'h0001;
         end
      end
   end
   // Periods counted inside the interval
   always_ff @(posedge mclk) begin
      if (sys_rst || state_r == pfm_word_pkg::MS_WAIT) begin
         per_r <= 6'h00;
      end else if (rise) begin
         per_r <= last_per ? 6'h00 : per_r + 6'h01;
      end
   end
   // Lowest digit wins if limit ranges overlap
   always_comb begin
      dig_nxt = 3'h0;
      hit_nxt = 1'b0;
      for (int k = 7; k >= 0; k--) begin
         if (cnt_r >= lim_lo[k] && cnt_r <= lim_hi[k]) begin
            dig_nxt = 3'(k);
            hit_nxt = 1'b1;
         end
      end
      sync_nxt = sync_win && cnt_r >= sync_lo && cnt_r <= sync_hi;
   end
   // Result registers, valid as the interval closes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         done_r <= 1'b0;
         dig_r <= 3'h0;
         hit_r <= 1'b0;
         sync_r <= 1'b0;
         movf_r <= 1'b0;
         count_r <= 13'h0000;
      end else begin
         done_r <= state_r == pfm_word_pkg::MS_RUN && rise && last_per;
         if (state_r == pfm_word_pkg::MS_RUN && rise && last_per) begin
            dig_r <= dig_nxt;
            hit_r <= hit_nxt & ~ovf_r;
            sync_r <= sync_nxt & ~ovf_r;
            movf_r <= ovf_r;
            count_r <= cnt_r;
         end
      end
   end
   assign m.done = done_r;
   assign m.digit = dig_r;
   assign m.in_range = hit_r;
   assign m.sync_hit = sync_r;
   assign m.ovf = movf_r;
   assign m.count = count_r;
endmodule

//--- pfm_octal_word_assembler.sv
// Top: PFM octal digit decoder, channel marks, word assembly, Avalon-MM registers
`timescale 1ns/1ns
`include "pfm_word_consts.svh"
module pfm_octal_word_assembler #(
   parameter int NUM_WORDS = 8,
   parameter int MAX_DIGITS = 5,
   parameter int NUM_MARKS = 96
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic pfm_in,
   input wire logic [3:0] frame_num,
   input wire logic [3:0] chan_num,
   input wire logic [255:0] chan_pulse,
   output logic [NUM_WORDS-1:0] word_full,
   output logic irq
);
   // Derived sizes
   localparam int HOLD_W = 3 * MAX_DIGITS;
   localparam int MI_W = $clog2(NUM_MARKS);
   localparam int WI_W = (NUM_WORDS > 1) ? $clog2(NUM_WORDS) : 1;
   localparam int NUM_LIM = 18;
   localparam logic [11:0] MARK_END = `REG_MARK_BASE + 12'(NUM_MARKS * 4);
   localparam logic [11:0] HOLD_END = `REG_HOLD_BASE + 12'(NUM_WORDS * 4);

   // Bus handshake state
   logic req; // Read or write pending
   logic ack_r; // Second cycle of an access
   logic wr_go; // Write takes effect this edge
   logic [11:0] addr; // Word aligned byte address
   logic [31:0] rd_nxt; // Readback of addressed register
   logic [31:0] rdata_r; // Registered read data
   logic [31:0] wr_word; // Write data merged by byte lanes

   // Decoded register windows
   logic lim_sel, mark_sel, hold_sel;
   logic [4:0] lim_idx;
   logic [MI_W-1:0] mark_idx;
   logic [WI_W-1:0] hold_idx;

   // Software visible state
   logic [31:0] ctrl_r; // Enable, clock ratio, periods
   logic [12:0] lim_r [NUM_LIM]; // Upper/lower pairs, then sync
   logic [31:0] mark_r [NUM_MARKS]; // Channel mark routing table
   logic [3:0] irq_stat_r; // Sticky event bits
   logic [3:0] irq_en_r; // Interrupt enables
   logic [3:0] irq_ev; // Events this cycle
   logic [3:0] irq_clr; // Write-one-to-clear mask

   // Word assembly state
   logic [NUM_MARKS-1:0] mark_n; // Active-low channel marks
   logic [NUM_WORDS-1:0][MAX_DIGITS-1:0] cell_mark; // Mark per digit slot
   logic [NUM_WORDS-1:0] last_hit; // Final channel of word seen
   logic [NUM_WORDS-1:0] full_r; // Word full flags
   logic [NUM_WORDS-1:0] full_clr; // Software clear of full flags
   logic [NUM_WORDS-1:0] xfer_r; // Transfer pulse per word
   logic [NUM_WORDS-1:0] clr_r; // Clear pulse per word
   logic [NUM_WORDS-1:0][HOLD_W-1:0] cell_q; // Cell outputs
   logic [HOLD_W-1:0] hold_r [NUM_WORDS]; // Hold registers
   logic [2:0] wi, di; // Table fields under scan

   // Meter hookup
   logic [7:0][12:0] lim_hi, lim_lo;
   logic sync_win;
   pfm_meas_if meas ();

   // Replace disabled byte lanes with the current contents
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Every access takes two cycles: one wait, one completion
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_go = avs_write & ack_r;
   assign addr = {avs_address[11:2], 2'b00};
   assign avs_readdata = rdata_r;

   // Acknowledge follows the first cycle of each request
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Read data captured in the wait cycle, stable at completion
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read && !ack_r) begin
         rdata_r <= rd_nxt;
      end
   end

   // Window decode
   assign lim_sel = addr >= `REG_LIM_BASE && addr < `REG_LIM_END;
   assign mark_sel = addr >= `REG_MARK_BASE && addr < MARK_END;
   assign hold_sel = addr >= `REG_HOLD_BASE && addr < HOLD_END;
   assign lim_idx = 5'((addr - `REG_LIM_BASE) >> 2);
   assign mark_idx = MI_W'((addr - `REG_MARK_BASE) >> 2);
   assign hold_idx = WI_W'((addr - `REG_HOLD_BASE) >> 2);

   // Readback mux; unmapped and write-only offsets read zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (addr == `REG_CTRL) begin
         rd_nxt = ctrl_r;
      end else if (addr == `REG_IRQ_STAT) begin
         rd_nxt = {28'h000_0000, irq_stat_r};
      end else if (addr == `REG_IRQ_EN) begin
         rd_nxt = {28'h000_0000, irq_en_r};
      end else if (addr == `REG_MEAS) begin
         // Latest measurement, shows the meter's result registers
         rd_nxt[12:0] = meas.count;
         rd_nxt[`MEAS_DIGIT_LSB +: 3] = meas.digit;
         rd_nxt[`MEAS_HIT_BIT] = meas.in_range;
         rd_nxt[`MEAS_SYNC_BIT] = meas.sync_hit;
         rd_nxt[`MEAS_OVF_BIT] = meas.ovf;
      end else if (addr == `REG_FULL) begin
         rd_nxt = 32'(full_r);
      end else if (lim_sel) begin
         rd_nxt = 32'(lim_r[lim_idx]);
      end else if (mark_sel) begin
         rd_nxt = mark_r[mark_idx];
      end else if (hold_sel) begin
         rd_nxt = 32'(hold_r[hold_idx]);
      end
   end

   // Byte-lane merge against the old value
   assign wr_word = be_merge(rd_nxt, avs_writedata, avs_byteenable);

   // Control register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_r <= `CTRL_RST;
      end else if (wr_go && addr == `REG_CTRL) begin
         ctrl_r <= wr_word & `CTRL_WMASK;
      end
   end

   // Limit registers, every bit settable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_LIM; i++) begin
            lim_r[i] <= `LIM_RST;
         end
      end else if (wr_go && lim_sel) begin
         lim_r[lim_idx] <= wr_word[12:0];
      end
   end

   // Channel mark routing table
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_MARKS; i++) begin
            mark_r[i] <= 32'h0000_0000;
         end
      end else if (wr_go && mark_sel) begin
         mark_r[mark_idx] <= wr_word & `MARK_WMASK;
      end
   end

   // Interrupt enables
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_en_r <= 4'h0;
      end else if (wr_go && addr == `REG_IRQ_EN) begin
         irq_en_r <= wr_word[3:0];
      end
   end

   // Limit pairs to the meter: even index upper, odd lower
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         lim_hi[k] = lim_r[2*k];
         lim_lo[k] = lim_r[2*k+1];
      end
   end

   // Sync oscillator lives only in channel zero of odd frames
   assign sync_win = chan_num == 4'h0 && frame_num[0];

   // Period measurement and digit decode
   pfm_period_meter u_meter (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .enable(ctrl_r[`CTRL_EN_BIT]),
      .pfm_in(pfm_in),
      .ratio(ctrl_r[`CTRL_RATIO_LSB +: 3]),
      .avg_periods(ctrl_r[`CTRL_AVG_LSB +: 6]),
      .lim_hi(lim_hi),
      .lim_lo(lim_lo),
      .sync_hi(lim_r[`LIM_SYNC_IDX]),
      .sync_lo(lim_r[`LIM_SYNC_IDX+1]),
      .sync_win(sync_win),
      .m(meas.meter)
   );

   // Channel pulses picked by the table, in inverted form
   always_comb begin
      mark_n = '1;
      for (int k = 0; k < NUM_MARKS; k++) begin
         // Only a decoded digit may mark; a miss would store garbage
         if (mark_r[k][`MARK_EN_BIT] && chan_pulse[mark_r[k][`MARK_CHAN_LSB +: 8]]
             && meas.done && meas.in_range) begin
            mark_n[k] = 1'b0;
         end
      end
   end

   // Fan marks out to word and digit slots
   always_comb begin
      cell_mark = '0;
      last_hit = '0;
      wi = 3'h0;
      di = 3'h0;
      for (int k = 0; k < NUM_MARKS; k++) begin
         wi = mark_r[k][`MARK_WORD_LSB +: 3];
         di = mark_r[k][`MARK_DIGIT_LSB +: 3];
         // Slots beyond the built size are ignored
         if (!mark_n[k] && int'(wi) < NUM_WORDS && int'(di) < MAX_DIGITS) begin
            cell_mark[wi][di] = 1'b1;
            if (mark_r[k][`MARK_LAST_BIT]) begin
               last_hit[wi] = 1'b1;
            end
         end
      end
   end

   // Three cells per digit slot, one per digit weight
   for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
      for (genvar d = 0; d < MAX_DIGITS; d++) begin : g_digit
         for (genvar b = 0; b < 3; b++) begin : g_bit
            pfm_mem_cell u_cell (
               .mclk(mclk),
               .sys_rst(sys_rst),
               .mark(cell_mark[w][d]),
               .info(meas.digit[b]),
               .xfer(xfer_r[w]),
               .clr(clr_r[w]),
               .q_out(cell_q[w][3*d+b])
            );
         end
      end
   end

   // Transfer follows the final mark, clear follows transfer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         xfer_r <= '0;
         clr_r <= '0;
      end else begin
         xfer_r <= last_hit;
         clr_r <= xfer_r;
      end
   end

   // Hold registers load the whole word at once
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            hold_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            if (xfer_r[i]) begin
               hold_r[i] <= cell_q[i];
            end
         end
      end
   end

   // Full flags: set wins over a software clear in the same cycle
   assign full_clr = (wr_go && addr == `REG_FULL) ? wr_word[NUM_WORDS-1:0] : '0;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         full_r <= '0;
      end else begin
         full_r <= (full_r & ~full_clr) | last_hit;
      end
   end
   assign word_full = full_r;

   // Event sources for the sticky status
   always_comb begin
      irq_ev = 4'h0;
      irq_ev[`IRQ_FULL_BIT] = |last_hit;
      irq_ev[`IRQ_SYNC_BIT] = meas.done & meas.sync_hit;
      irq_ev[`IRQ_RANGE_BIT] = meas.done & ~meas.in_range;
      irq_ev[`IRQ_OVF_BIT] = meas.done & meas.ovf;
   end

   // Sticky status; a new event beats a clear in the same cycle
   assign irq_clr = (wr_go && addr == `REG_IRQ_CLR) ? wr_word[3:0] : 4'h0;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_stat_r <= 4'h0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      end
   end

   // Level interrupt while any enabled status bit is set
   assign irq = |(irq_stat_r & irq_en_r);
endmodule

//--- pfm_word_chk.sv
// Concurrent checks on the ports of the octal word assembler
`timescale 1ns/1ns
`include "pfm_word_consts.svh"
module pfm_word_chk #(
   parameter int NUM_WORDS = 8
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [255:0] chan_pulse,
   input wire logic [NUM_WORDS-1:0] word_full,
   input wire logic irq
);
   // One clock domain, so one clock and reset for all
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Access completing at this edge
   wire logic done_wr = avs_write && !avs_waitrequest;
   wire logic done_rd = avs_read && !avs_waitrequest;
   // Start of a request, then one wait and the answer
   sequence s_req_start;
      $rose(avs_read || avs_write);
   endsequence
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   property p_one_wait;
      s_req_start |-> s_one_wait;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("request did not get exactly one wait cycle");
   property p_idle_nowait;
      !(avs_read || avs_write) |-> !avs_waitrequest;
   endproperty
   a_idle_nowait: assert property (p_idle_nowait)
      else $error("wait raised with no request");
   // Outputs quiet right after reset
   property p_rst_quiet;
      $fell(sys_rst) |-> !irq && word_full == '0 && avs_readdata == 32'h0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs not at reset values");
   // Flags only fall through a write to the full register
   property p_full_sticky;
      !$past(sys_rst || (done_wr && avs_address == `REG_FULL)) |-> (word_full & $past(word_full)) == $past(word_full);
   endproperty
   a_full_sticky: assert property (p_full_sticky)
      else $error("full flag dropped without a clear");
   // A new full flag needs a live channel pulse one cycle earlier
   property p_full_cause;
      (word_full & ~$past(word_full)) != '0 |-> $past(chan_pulse) != '0;
   endproperty
   a_full_cause: assert property (p_full_cause)
      else $error("full flag set with no channel pulse");
   property p_irq_masked;
      done_wr && avs_address == `REG_IRQ_EN && avs_byteenable[0] && avs_writedata[3:0] == 4'h0 |=> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt high with all sources masked");
   property p_clr_zero;
      done_rd && avs_address == `REG_IRQ_CLR |-> avs_readdata == 32'h0;
   endproperty
   a_clr_zero: assert property (p_clr_zero)
      else $error("clear register did not read zero");
   property p_ctrl_fields;
      done_rd && avs_address == `REG_CTRL |-> (avs_readdata & ~`CTRL_WMASK) == 32'h0;
   endproperty
   a_ctrl_fields: assert property (p_ctrl_fields)
      else $error("control read shows bits outside its fields");
   // Count is thirteen bits, digit three bits
   property p_meas_width;
      done_rd && avs_address == `REG_MEAS |-> avs_readdata[15:13] == 3'h0 && avs_readdata[31:23] == 9'h0;
   endproperty
   a_meas_width: assert property (p_meas_width)
      else $error("measurement read shows bits outside its fields");
endmodule
bind pfm_octal_word_assembler pfm_word_chk #(.NUM_WORDS(NUM_WORDS)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .chan_pulse(chan_pulse), .word_full(word_full), .irq(irq));

//--- pfm_frame_src.sv
// Frame and channel source with a square PFM tone of set period
`timescale 1ns/1ns
module pfm_frame_src (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [15:0] period,
   input wire logic [3:0] frame_sel,
   input wire logic [3:0] chan_sel,
   output logic pfm_in,
   output logic [3:0] frame_num,
   output logic [3:0] chan_num,
   output logic [255:0] chan_pulse
);
   logic [15:0] phase_r; // Cycle within one tone period
   // Tone phase; a shorter new period wraps at once
   always_ff @(posedge mclk) begin
      if (sys_rst || phase_r >= period - 16'h0001) begin
         phase_r <= 16'h0000;
      end else begin
         phase_r <= phase_r + 16'h0001;
      end
   end
   // High in the first half, so one rise per period
   assign pfm_in = (phase_r < (period >> 1));
   // Frame grid position, held by the bench
   assign frame_num = frame_sel;
   assign chan_num = chan_sel;
   // One line per frame and channel pair, index frame*16+chan
   assign chan_pulse = 256'h1 << {frame_sel, chan_sel};
endmodule

//--- tb_pfm_octal_word_assembler.sv
// Self-checking bench for the octal word assembler
`timescale 1ns/1ns
`include "pfm_word_consts.svh"
module tb_pfm_octal_word_assembler;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] period = 16'h0020;
   logic [3:0] frame_sel = 4'h0;
   logic [3:0] chan_sel = 4'h0;
   logic pfm_in;
   logic [3:0] frame_num;
   logic [3:0] chan_num;
   logic [255:0] chan_pulse;
   logic [7:0] word_full;
   logic irq;
   logic [31:0] scratch; // Unused read result
   int err_count = 0;
   int comparisons = 0;
   // 125 MHz clock
   always #4 mclk = ~mclk;
   pfm_frame_src u_src (.mclk(mclk), .sys_rst(sys_rst), .period(period), .frame_sel(frame_sel),
      .chan_sel(chan_sel), .pfm_in(pfm_in), .frame_num(frame_num), .chan_num(chan_num), .chan_pulse(chan_pulse));
   pfm_octal_word_assembler #(.NUM_WORDS(8), .MAX_DIGITS(5), .NUM_MARKS(96)) u_dut (.mclk(mclk),
      .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pfm_in(pfm_in), .frame_num(frame_num), .chan_num(chan_num),
      .chan_pulse(chan_pulse), .word_full(word_full), .irq(irq));
   // Verdict and end of run
   task automatic finish_test;
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon access; held until wait is seen low
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      q = 32'h0000_0000;
      // Wait and read data are sampled at the rising edge only
      for (i = 0; i < 16; i++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) begin
            q = avs_readdata;
            break;
         end
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 16) begin
         err_count++;
         $display("ERROR at %0t: bus timeout", $time);
         finish_test();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d, scratch);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk(v, exp);
   endtask
   // Run a tone long enough for three full intervals, then read the result
   task automatic meas(input logic [2:0] r, input logic [5:0] n, input int p, input logic [3:0] f,
      input logic [2:0] d, input logic s);
      logic [31:0] v;
      wr(`REG_CTRL, {18'h0, n, 1'b0, r, 3'h0, 1'b1});
      period <= 16'(p);
      frame_sel <= f;
      chan_sel <= 4'h0;
      repeat (3 * int'(n) * p + 40) @(posedge mclk);
      bus(1'b0, `REG_MEAS, 32'h0, v);
      chk({25'h0, v[22:16]}, {25'h0, 1'b0, s, 1'b1, 1'b0, d});
   endtask
   // Reset values, an unmapped place and the write-only clear
   task automatic t_reset;
      rdc(`REG_CTRL, `CTRL_RST);
      rdc(`REG_IRQ_STAT, 32'h0);
      rdc(`REG_IRQ_CLR, 32'h0);
      rdc(12'h0C0, 32'h0);
      chk({24'h0, word_full}, 32'h0);
   endtask
   // Limit width, then ranges 20<<k +-2 for digit k and sync at 320
   task automatic t_limits;
      wr(`REG_LIM_BASE, 32'hFFFF_FFFF);
      rdc(`REG_LIM_BASE, 32'h0000_1FFF);
      for (int k = 0; k < 8; k++) begin
         wr(`REG_LIM_BASE + 12'(8 * k), 32'((20 << k) + 2));
         wr(`REG_LIM_BASE + 12'(8 * k + 4), 32'((20 << k) - 2));
      end
      wr(`REG_LIM_BASE + 12'h040, 32'd322);
      wr(`REG_LIM_BASE + 12'h044, 32'd318);
   endtask
   task automatic t_digits;
      for (int k = 0; k < 8; k++) meas(3'h4, 6'd10, 2 << k, 4'h0, 3'(k), 1'b0);
   endtask
   task automatic t_ratios;
      for (int r = 0; r < 5; r++) meas(3'(r), 6'd10, 32, 4'h0, 3'(r), 1'b0);
   endtask
   task automatic t_avg;
      meas(3'h4, 6'd5, 32, 4'h0, 3'h3, 1'b0);
      meas(3'h4, 6'd20, 16, 4'h0, 3'h4, 1'b0);
   endtask
   task automatic t_sync;
      meas(3'h4, 6'd10, 32, 4'h1, 3'h4, 1'b1);
      meas(3'h4, 6'd10, 32, 4'h2, 3'h4, 1'b0);
   endtask
   // Settle a tone on an idle channel, then show one channel to the marks
   task automatic feed(input logic [7:0] idx, input int p, input logic last);
      int i;
      chan_sel <= 4'h0;
      frame_sel <= 4'h0;
      period <= 16'(p);
      repeat (30 * p + 40) @(posedge mclk);
      {frame_sel, chan_sel} <= idx;
      for (i = 0; i < 40 * p; i++) begin
         @(posedge mclk);
         if (last && word_full[2] === 1'b1) break;
      end
      {frame_sel, chan_sel} <= 8'h00;
      if (last && i == 40 * p) begin
         err_count++;
         $display("ERROR at %0t: word full timeout", $time);
         finish_test();
      end
   endtask
   // Two-digit word 2 from channels 0x11 and 0x12, then clear and reuse
   task automatic t_word;
      logic [31:0] v;
      wr(`REG_MARK_BASE, 32'h8000_2011);
      wr(`REG_MARK_BASE + 12'h004, 32'h8001_2112);
      wr(`REG_CTRL, 32'h0000_0A41);
      feed(8'h11, 16, 1'b0);
      feed(8'h00, 128, 1'b0);
      chk({24'h0, word_full}, 32'h0);
      feed(8'h12, 128, 1'b1);
      chk({24'h0, word_full}, 32'h4);
      rdc(`REG_HOLD_BASE + 12'h008, 32'h33);
      bus(1'b0, `REG_IRQ_STAT, 32'h0, v);
      chk({31'h0, v[0]}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      // A write lands at the edge that ends the access, so look one edge later
      wr(`REG_IRQ_EN, 32'h1);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      wr(`REG_IRQ_CLR, 32'h1);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      wr(`REG_FULL, 32'h4);
      @(posedge mclk);
      chk({24'h0, word_full}, 32'h0);
      feed(8'h12, 16, 1'b1);
      rdc(`REG_HOLD_BASE + 12'h008, 32'h18);
      chk({31'h0, irq}, 32'h1);
      wr(`REG_IRQ_EN, 32'h0);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset();
      t_limits();
      t_digits();
      t_ratios();
      t_avg();
      t_sync();
      t_word();
      finish_test();
   end
endmodule
